// ===== design/duart_interrupt_request_n_pkg.sv
// Shared addresses, field positions, command codes and reset values
package duart_interrupt_request_n_pkg;

	localparam logic [3:0] ADDR_MASKED_STATUS = 4'h2;
	localparam logic [3:0] ADDR_CMD_A         = 4'h2;
	localparam logic [3:0] ADDR_CHANGE_READ   = 4'h4;
	localparam logic [3:0] ADDR_STATUS        = 4'h5;
	localparam logic [3:0] ADDR_MASK          = 4'h5;
	localparam logic [3:0] ADDR_CMD_B         = 4'ha;
	localparam logic [3:0] ADDR_VECTOR        = 4'hc;
	localparam logic [3:0] ADDR_CNT_START     = 4'he;
	localparam logic [3:0] ADDR_OUT_SET       = 4'he;
	localparam logic [3:0] ADDR_CNT_STOP      = 4'hf;
	localparam logic [3:0] ADDR_OUT_CLEAR     = 4'hf;

	localparam int BIT_TX_READY_A   = 0;
	localparam int BIT_RX_READY_A   = 1;
	localparam int BIT_BREAK_A      = 2;
	localparam int BIT_COUNTER      = 3;
	localparam int BIT_TX_READY_B   = 4;
	localparam int BIT_RX_READY_B   = 5;
	localparam int BIT_BREAK_B      = 6;
	localparam int BIT_INPUT_CHANGE = 7;

	localparam int CMD_MSB = 7;
	localparam int CMD_LSB = 4;

	localparam logic [3:0] CMD_RESET_BREAK = 4'h5;
	localparam logic [3:0] CMD_STANDBY     = 4'hc;
	localparam logic [3:0] CMD_ACTIVE      = 4'hd;

	localparam int WATCHED_INPUTS = 4;

	localparam logic [7:0] MASK_RESET   = 8'h00;
	localparam logic [7:0] VECTOR_RESET = 8'h00;
	localparam logic [7:0] OUT_REG_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE    = 8'h00;

	typedef enum logic [1:0] {
		PWR_ACTIVE  = 2'b01,
		PWR_STANDBY = 2'b10
	} power_e;

	typedef enum logic [2:0] {
		INT_NORMAL    = 3'b001,
		INT_Z_IDLE    = 3'b010,
		INT_Z_SERVICE = 3'b100
	} int_mode_e;

endpackage

// ===== design/input_change_detect.sv
// Synchroniser and change-of-state detector for the watched input pins
`timescale 1ns/100ps
`default_nettype none
module input_change_detect
	import duart_interrupt_request_n_pkg::*;
(
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic [WATCHED_INPUTS-1:0] inputPins,
	output logic                           changeSeen_r
);

	logic [WATCHED_INPUTS-1:0] meta_r;
	logic [WATCHED_INPUTS-1:0] sync_r;
	logic [WATCHED_INPUTS-1:0] last_r;
	logic                      settle_r;
	logic                      settled_r;
	logic                      primed_r;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= inputPins;
			sync_r <= meta_r;
		end
	end

	// Priming waits until both compared samples come from the pins, not from reset
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			last_r       <= '0;
			settle_r     <= 1'b0;
			settled_r    <= 1'b0;
			primed_r     <= 1'b0;
			changeSeen_r <= 1'b0;
		end
		else
		begin
			last_r       <= sync_r;
			settle_r     <= 1'b1;
			settled_r    <= settle_r;
			primed_r     <= settled_r;
			changeSeen_r <= primed_r && (|(sync_r ^ last_r)); // [R12]
		end
	end

endmodule
`default_nettype wire

// ===== design/output_port_reg.sv
// Output port register with set and clear strobes and inverted pins
`timescale 1ns/100ps
`default_nettype none
module output_port_reg
	import duart_interrupt_request_n_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       setStrobe,
	input  wire logic       clearStrobe,
	input  wire logic [7:0] bitData,
	output logic [7:0]      outputPins_r
);

	logic [7:0] outReg_r;
	logic [7:0] outReg_nxt;

	always_comb
	begin
		outReg_nxt = outReg_r;
		if (setStrobe)
			outReg_nxt = outReg_r | bitData; // [R9]
		else if (clearStrobe)
			outReg_nxt = outReg_r & ~bitData; // [R6]
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			outReg_r     <= OUT_REG_RESET;
			outputPins_r <= ~OUT_REG_RESET;
		end
		else
		begin
			outReg_r     <= outReg_nxt;
			outputPins_r <= ~outReg_nxt; // [R10]
		end
	end

endmodule
`default_nettype wire

// ===== design/duart_interrupt_and_command_logic.sv
// Interrupt status, mask, vector and chip-wide command decoding
//
// Operation
// [R1] Standby code on channel A command register powers down the whole chip.
// [R2] Hardware reset or set-active command leaves standby.
// [R3] Set-active code on channel A command register exits standby.
// [R4] Standby code on channel B clears under-service latch in daisy mode.
// [R5] Set-active code on channel B selects daisy-chain interrupt mode.
// [R6] Counter start, stop, output set and clear fire by bus address alone.
// [R7] Reading address 0E starts the counter.
// [R8] That triggering read returns no register contents.
// [R9] Writing 0E sets output register bits written as one.
// [R10] Each output pin shows the inverse of its register bit.
// [R11] Interrupt request can follow every listed event when unmasked.
// [R12] Change on the four lowest inputs raises the input change condition.
// [R13] Address 05 reads status and writes the mask.
// [R14] Masked status at 02, vector at 0C.
// [R15] Status bits: 7 input, 6..4 channel B, 3 counter, 2..0 channel A.
// [R16] Status bits show conditions regardless of the mask.
// [R17] Service routine reads status or masked status first.
// [R18] Masked status equals status AND mask.
// [R19] Mask one enables a source, zero blocks it.
// [R20] Reset clears mask, standby, daisy mode and latch; request released.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module duart_interrupt_and_command_logic
	import duart_interrupt_request_n_pkg::*;
(
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic [3:0]                busAddr,
	input  wire logic [7:0]                busWrData,
	input  wire logic                      busWr,
	input  wire logic                      busRd,
	output logic [7:0]                     busRdData_r,
	input  wire logic                      transmitReadyFlagA,
	input  wire logic                      receiveReadyFlagA,
	input  wire logic                      breakChangeA,
	input  wire logic                      transmitReadyFlagB,
	input  wire logic                      receiveReadyFlagB,
	input  wire logic                      breakChangeB,
	input  wire logic                      counterEndOfCount,
	input  wire logic [WATCHED_INPUTS-1:0] inputPins,
	input  wire logic                      interruptAckN,
	output logic [7:0]                     outputPins_r,
	output logic                           counterStart_r,
	output logic                           counterStop_r,
	output logic                           lowPowerStandby_r,
	output logic                           daisyChainMode_r,
	output logic                           interruptRequestN_r,
	output logic                           daisyChainEnableOut_r
);

	power_e     power_r;
	power_e     power_nxt;
	int_mode_e  intMode_r;
	int_mode_e  intMode_nxt;
	logic [7:0] interruptMask_r;
	logic [7:0] interruptVector_r;
	logic [7:0] interruptStatus;
	logic [7:0] maskedStatus;
	logic       breakA_r;
	logic       breakB_r;
	logic       counterReady_r;
	logic       inputChange_r;
	logic       inputChangePulse;
	logic       ackMeta_r;
	logic       ackSync_r;
	logic       ackLast_r;
	logic       ackEdge;
	logic       cmdWriteA;
	logic       cmdWriteB;
	logic [3:0] cmdCode;
	logic       anyPending;
	logic [7:0] readValue;
	logic       standbyCmdA;
	logic       activeCmdA;
	logic       breakResetA;
	logic       latchResetB;
	logic       daisyCmdB;
	logic       breakResetB;
	logic       maskWrite;
	logic       vectorWrite;
	logic       outSetWrite;
	logic       outClearWrite;
	logic       cntStartRead;
	logic       cntStopRead;
	logic       changeRead;
	logic       requestAllowed;

	function automatic logic hit(input logic strobe, input logic [3:0] addr,
		input logic [3:0] target);
		hit = strobe && (addr == target);
	endfunction

	function automatic logic cmdIs(input logic strobe, input logic [3:0] code,
		input logic [3:0] target);
		cmdIs = strobe && (code == target);
	endfunction

	assign cmdWriteA = hit(busWr, busAddr, ADDR_CMD_A);
	assign cmdWriteB = hit(busWr, busAddr, ADDR_CMD_B);
	assign cmdCode   = busWrData[CMD_MSB:CMD_LSB];

	// Channel A commands
	assign standbyCmdA = cmdIs(cmdWriteA, cmdCode, CMD_STANDBY);
	assign activeCmdA  = cmdIs(cmdWriteA, cmdCode, CMD_ACTIVE);
	assign breakResetA = cmdIs(cmdWriteA, cmdCode, CMD_RESET_BREAK);

	// Channel B reuses the same codes; standby and active take daisy-chain meanings
	assign latchResetB = cmdIs(cmdWriteB, cmdCode, CMD_STANDBY);
	assign daisyCmdB   = cmdIs(cmdWriteB, cmdCode, CMD_ACTIVE);
	assign breakResetB = cmdIs(cmdWriteB, cmdCode, CMD_RESET_BREAK);

	// Address-triggered strobes act on the address alone
	assign maskWrite     = hit(busWr, busAddr, ADDR_MASK);
	assign vectorWrite   = hit(busWr, busAddr, ADDR_VECTOR);
	assign outSetWrite   = hit(busWr, busAddr, ADDR_OUT_SET);
	assign outClearWrite = hit(busWr, busAddr, ADDR_OUT_CLEAR);
	assign cntStartRead  = hit(busRd, busAddr, ADDR_CNT_START);
	assign cntStopRead   = hit(busRd, busAddr, ADDR_CNT_STOP);
	assign changeRead    = hit(busRd, busAddr, ADDR_CHANGE_READ);

	input_change_detect u_change
	(
		.clk_sys      (clk_sys),
		.rst_n        (rst_n),
		.inputPins    (inputPins),
		.changeSeen_r (inputChangePulse)
	);

	output_port_reg u_outport
	(
		.clk_sys      (clk_sys),
		.rst_n        (rst_n),
		.setStrobe    (outSetWrite),
		.clearStrobe  (outClearWrite),
		.bitData      (busWrData),
		.outputPins_r (outputPins_r)
	);

	// Acknowledge pin comes from the host side and is not on this clock
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ackMeta_r <= 1'b1;
			ackSync_r <= 1'b1;
			ackLast_r <= 1'b1;
		end
		else
		begin
			ackMeta_r <= interruptAckN;
			ackSync_r <= ackMeta_r;
			ackLast_r <= ackSync_r;
		end
	end

	// Only the falling edge counts, so an acknowledge held low latches once
	assign ackEdge = ackLast_r && !ackSync_r;

	// Power mode: reset forces active, so a chip left in standby always wakes up
	always_comb
	begin
		power_nxt = power_r;
		unique case (power_r)
			PWR_ACTIVE:
			begin
				if (standbyCmdA)
					power_nxt = PWR_STANDBY; // [R1]
			end
			PWR_STANDBY:
			begin
				if (activeCmdA)
					power_nxt = PWR_ACTIVE; // [R2] [R3]
			end
			default:
				power_nxt = PWR_ACTIVE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			power_r           <= PWR_ACTIVE; // [R2] [R20]
			lowPowerStandby_r <= 1'b0;
		end
		else
		begin
			power_r           <= power_nxt;
			lowPowerStandby_r <= (power_nxt == PWR_STANDBY); // [R1]
		end
	end

	// Interrupt mode: normal, or daisy chain with an under-service latch
	always_comb
	begin
		intMode_nxt = intMode_r;
		unique case (intMode_r)
			INT_NORMAL:
			begin
				if (daisyCmdB)
					intMode_nxt = INT_Z_IDLE; // [R5]
			end
			INT_Z_IDLE:
			begin
				if (ackEdge && anyPending)
					intMode_nxt = INT_Z_SERVICE;
			end
			INT_Z_SERVICE:
			begin
				if (latchResetB)
					intMode_nxt = INT_Z_IDLE; // [R4]
			end
			default:
				intMode_nxt = INT_NORMAL;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			intMode_r             <= INT_NORMAL; // [R20]
			daisyChainMode_r      <= 1'b0;
			daisyChainEnableOut_r <= 1'b1;
		end
		else
		begin
			intMode_r             <= intMode_nxt;
			daisyChainMode_r      <= (intMode_nxt != INT_NORMAL);
			daisyChainEnableOut_r <= (intMode_nxt != INT_Z_SERVICE); // [R4]
		end
	end

	// Mask and vector registers; the mask cannot be read back
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			interruptMask_r <= MASK_RESET; // [R20]
		else if (maskWrite)
			interruptMask_r <= busWrData; // [R13] [R19]
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			interruptVector_r <= VECTOR_RESET;
		else if (vectorWrite)
			interruptVector_r <= busWrData; // [R14]
	end

	// Sticky conditions: a set in the same cycle as its clear wins
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			breakA_r       <= 1'b0;
			breakB_r       <= 1'b0;
			counterReady_r <= 1'b0;
			inputChange_r  <= 1'b0;
		end
		else
		begin
			breakA_r <= breakChangeA ||
				(breakA_r && !breakResetA); // [R11]
			breakB_r <= breakChangeB ||
				(breakB_r && !breakResetB); // [R11]
			counterReady_r <= counterEndOfCount ||
				(counterReady_r && !cntStopRead); // [R11]
			inputChange_r <= inputChangePulse ||
				(inputChange_r && !changeRead); // [R12]
		end
	end

	// Ready flags are live levels from the channels, so they clear with them
	always_comb
	begin
		interruptStatus                   = '0;
		interruptStatus[BIT_TX_READY_A]   = transmitReadyFlagA; // [R15] [R16]
		interruptStatus[BIT_RX_READY_A]   = receiveReadyFlagA;
		interruptStatus[BIT_BREAK_A]      = breakA_r;
		interruptStatus[BIT_COUNTER]      = counterReady_r;
		interruptStatus[BIT_TX_READY_B]   = transmitReadyFlagB;
		interruptStatus[BIT_RX_READY_B]   = receiveReadyFlagB;
		interruptStatus[BIT_BREAK_B]      = breakB_r;
		interruptStatus[BIT_INPUT_CHANGE] = inputChange_r;
	end

	assign maskedStatus = interruptStatus & interruptMask_r; // [R18] [R19]
	assign anyPending   = |maskedStatus; // [R11]
	assign requestAllowed = (intMode_nxt != INT_Z_SERVICE);

	// Under service the request is withheld until the latch is reset
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			interruptRequestN_r <= 1'b1; // [R20]
		else
			interruptRequestN_r <= !(anyPending && requestAllowed); // [R11]
	end

	// Counter strobes are one-cycle pulses to the counter block
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			counterStart_r <= 1'b0;
			counterStop_r  <= 1'b0;
		end
		else
		begin
			counterStart_r <= cntStartRead; // [R6] [R7]
			counterStop_r  <= cntStopRead; // [R6]
		end
	end

	// Read mux; the channel B command address and unmapped addresses return zero, while 02 reads masked status
	always_comb
	begin
		readValue = READ_IDLE;
		unique case (busAddr)
			ADDR_MASKED_STATUS: readValue = maskedStatus; // [R14] [R17]
			ADDR_STATUS:        readValue = interruptStatus; // [R13] [R17]
			ADDR_VECTOR:        readValue = interruptVector_r; // [R14]
			ADDR_CNT_START:     readValue = READ_IDLE; // [R8]
			ADDR_CNT_STOP:      readValue = READ_IDLE; // [R6]
			default:            readValue = READ_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			busRdData_r <= READ_IDLE;
		else if (busRd)
			busRdData_r <= readValue;
		else
			busRdData_r <= READ_IDLE;
	end

endmodule
`default_nettype wire

// ===== sim/duart_interrupt_request_n_chk.sv
// Port checks for the interrupt and command block
`timescale 1ns/100ps
`default_nettype none
module duart_interrupt_request_n_chk
	import duart_interrupt_request_n_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic [3:0] busAddr,
	input wire logic [7:0] busWrData,
	input wire logic       busWr,
	input wire logic       busRd,
	input wire logic [7:0] busRdData_r,
	input wire logic [7:0] outputPins_r,
	input wire logic       counterStart_r,
	input wire logic       counterStop_r,
	input wire logic       lowPowerStandby_r,
	input wire logic       daisyChainMode_r,
	input wire logic       interruptRequestN_r,
	input wire logic       daisyChainEnableOut_r
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence rdAt(logic [3:0] a);
		busRd && busAddr == a;
	endsequence
	sequence cmdAt(logic [3:0] a, logic [3:0] c);
		busWr && busAddr == a && busWrData[7:4] == c;
	endsequence
	start_pulse_a: assert property (rdAt(ADDR_CNT_START) |=> counterStart_r)
		else $error("counter start missing");
	trig_read_a: assert property (rdAt(ADDR_CNT_START) |=> busRdData_r == 8'h00)
		else $error("trigger read drove data");
	stop_pulse_a: assert property (rdAt(ADDR_CNT_STOP) |=> counterStop_r)
		else $error("counter stop missing");
	set_bits_a: assert property (busWr && busAddr == ADDR_OUT_SET |=>
		outputPins_r == ($past(outputPins_r) & ~$past(busWrData)))
		else $error("output set wrong");
	clear_bits_a: assert property (busWr && busAddr == ADDR_OUT_CLEAR |=>
		outputPins_r == ($past(outputPins_r) | $past(busWrData)))
		else $error("output clear wrong");
	enter_standby_a: assert property (cmdAt(ADDR_CMD_A, CMD_STANDBY) |=> lowPowerStandby_r)
		else $error("standby not entered");
	leave_standby_a: assert property (cmdAt(ADDR_CMD_A, CMD_ACTIVE) |=> !lowPowerStandby_r)
		else $error("standby not left");
	daisy_set_a: assert property (cmdAt(ADDR_CMD_B, CMD_ACTIVE) |=> daisyChainMode_r)
		else $error("daisy mode not set");
	latch_clear_a: assert property (cmdAt(ADDR_CMD_B, CMD_STANDBY) ##0 daisyChainMode_r
		|=> daisyChainEnableOut_r)
		else $error("latch not cleared");
	reset_state_a: assert property ($rose(rst_n) |-> interruptRequestN_r
		&& daisyChainEnableOut_r && !lowPowerStandby_r && !daisyChainMode_r)
		else $error("reset state wrong");
endmodule
bind duart_interrupt_and_command_logic duart_interrupt_request_n_chk chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .busAddr(busAddr), .busWrData(busWrData),
	.busWr(busWr), .busRd(busRd), .busRdData_r(busRdData_r), .outputPins_r(outputPins_r),
	.counterStart_r(counterStart_r), .counterStop_r(counterStop_r),
	.lowPowerStandby_r(lowPowerStandby_r), .daisyChainMode_r(daisyChainMode_r),
	.interruptRequestN_r(interruptRequestN_r),
	.daisyChainEnableOut_r(daisyChainEnableOut_r)
);
`default_nettype wire

// ===== sim/host_bus_model.sv
// Host processor model on the register bus
`timescale 1ns/100ps
`default_nettype none
module host_bus_model
	import duart_interrupt_request_n_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic [7:0] busRdData_r,
	output logic [3:0]      busAddr,
	output logic [7:0]      busWrData,
	output logic            busWr,
	output logic            busRd
);
	initial
	begin
		busAddr = 4'h0;
		busWrData = 8'h00;
		busWr = 1'b0;
		busRd = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		busWr <= 1'b1;
		busAddr <= a;
		busWrData <= d;
		@(posedge clk_sys);
		busWr <= 1'b0;
		// Released data shows junk so stale values never pass
		busWrData <= ~d;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		busRd <= 1'b1;
		busAddr <= a;
		@(posedge clk_sys);
		busRd <= 1'b0;
		#1;
		d = busRdData_r;
	endtask
	task automatic service(output logic [7:0] d);
		rd(ADDR_MASKED_STATUS, d);
	endtask
endmodule
`default_nettype wire

// ===== sim/duart_interrupt_and_command_logic_tb.sv
// Self-checking bench for the interrupt and command block
`timescale 1ns/100ps
`default_nettype none
module duart_interrupt_and_command_logic_tb;
	import duart_interrupt_request_n_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic [3:0] busAddr;
	logic [7:0] busWrData, busRdData_r, outputPins_r, rdv, v, output_port_register, stick;
	logic       busWr, busRd, txA, rxA, txB, rxB, ackN;
	logic       cntStart, cntStop, standby, daisy, reqN, enOut;
	logic [2:0] evt;
	logic [3:0] inputPins;
	int         n_fail = 0;
	int         check_count = 0;
	always #12.5 clk_sys = ~clk_sys;
	host_bus_model host (.clk_sys(clk_sys), .busRdData_r(busRdData_r), .busAddr(busAddr),
		.busWrData(busWrData), .busWr(busWr), .busRd(busRd));
	duart_interrupt_and_command_logic i_duart_interrupt_and_command_logic (
		.clk_sys(clk_sys), .rst_n(rst_n), .busAddr(busAddr), .busWrData(busWrData),
		.busWr(busWr), .busRd(busRd), .busRdData_r(busRdData_r),
		.transmitReadyFlagA(txA), .receiveReadyFlagA(rxA), .breakChangeA(evt[0]),
		.transmitReadyFlagB(txB), .receiveReadyFlagB(rxB), .breakChangeB(evt[1]),
		.counterEndOfCount(evt[2]), .inputPins(inputPins), .interruptAckN(ackN),
		.outputPins_r(outputPins_r), .counterStart_r(cntStart), .counterStop_r(cntStop),
		.lowPowerStandby_r(standby), .daisyChainMode_r(daisy),
		.interruptRequestN_r(reqN), .daisyChainEnableOut_r(enOut));
	function automatic logic [7:0] expStatus(logic [7:0] s);
		return s | {2'b00, rxB, txB, 2'b00, rxA, txA};
	endfunction
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic pulse(input int i);
		@(posedge clk_sys);
		evt[i] <= 1'b1;
		@(posedge clk_sys);
		evt <= 3'b000;
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		tally_and_finish;
	end
	initial
	begin
		{txA, rxA, txB, rxB, evt, inputPins} = '0;
		ackN = 1'b1;
		stick = 8'h00;
		output_port_register = 8'h00;
		void'($urandom(41));
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		chk("pins", outputPins_r, 8'hff);
		chk("flags", {4'h0, reqN, enOut, standby, daisy}, 8'h0c);
		repeat (8)
		begin
			{txA, rxA, txB, rxB} <= 4'($urandom);
			v = 8'($urandom);
			host.wr(ADDR_MASK, v);
			host.rd(ADDR_STATUS, rdv);
			chk("status", rdv, expStatus(stick));
			host.service(rdv);
			chk("masked", rdv, expStatus(stick) & v);
			chk("req", {7'h0, reqN}, {7'h0, ~|(expStatus(stick) & v)});
		end
		for (int i = 0; i < 3; i++)
			pulse(i);
		inputPins <= 4'h1 << ($urandom % 4);
		repeat (6) @(posedge clk_sys);
		stick = 8'hcc;
		host.wr(ADDR_MASK, 8'hff);
		host.rd(ADDR_STATUS, rdv);
		chk("sticky", rdv, expStatus(stick));
		chk("reqall", {7'h0, reqN}, 8'h00);
		host.wr(ADDR_CMD_A, {CMD_RESET_BREAK, 4'h0});
		host.wr(ADDR_CMD_B, {CMD_RESET_BREAK, 4'h0});
		host.rd(ADDR_CNT_STOP, rdv);
		chk("stop", {rdv[6:0], cntStop}, 8'h01);
		host.rd(ADDR_CHANGE_READ, rdv);
		host.rd(ADDR_STATUS, rdv);
		chk("cleared", rdv, expStatus(8'h00));
		v = 8'($urandom);
		host.wr(ADDR_VECTOR, v);
		host.rd(ADDR_VECTOR, rdv);
		chk("vector", rdv, v);
		host.rd(4'h0, rdv);
		chk("unmapped", rdv, 8'h00);
		repeat (4)
		begin
			v = 8'($urandom);
			host.wr(ADDR_OUT_SET, v);
			output_port_register |= v;
			chk("set", outputPins_r, ~output_port_register);
			v = 8'($urandom);
			host.wr(ADDR_OUT_CLEAR, v);
			output_port_register &= ~v;
			chk("clear", outputPins_r, ~output_port_register);
		end
		host.rd(ADDR_CNT_START, rdv);
		chk("trigread", rdv, 8'h00);
		chk("start", {7'h0, cntStart}, 8'h01);
		host.wr(ADDR_CMD_A, {CMD_STANDBY, 4'h0});
		chk("standby", {7'h0, standby}, 8'h01);
		host.wr(ADDR_CMD_A, {CMD_ACTIVE, 4'h0});
		chk("active", {7'h0, standby}, 8'h00);
		host.wr(ADDR_CMD_B, {CMD_ACTIVE, 4'h0});
		chk("daisy", {7'h0, daisy}, 8'h01);
		txA <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ackN <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("latched", {6'h0, enOut, reqN}, 8'h01);
		ackN <= 1'b1;
		host.wr(ADDR_CMD_B, {CMD_STANDBY, 4'h0});
		chk("unlatch", {7'h0, enOut}, 8'h01);
		host.wr(ADDR_CMD_A, {CMD_STANDBY, 4'h0});
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		chk("rerst", {6'h0, standby, daisy}, 8'h00);
		tally_and_finish;
	end
endmodule
`default_nettype wire
